/* src/rmu_pkg.sv */
// package for the repeater management unit
package rmu_pkg;
  localparam int CNT_W = 32;
  localparam int NPORT = 8;
  localparam int NGRP = 4;
  localparam int VAR_9 = 9;
  localparam int VAR_27 = 27;
  localparam int VAR_41 = 41;
  localparam int TEST_CYC = 16;
  localparam int MAX_PORT_CAP = 1024;
  // register offsets
  localparam logic [3:0] A_COLL = 4'h0;
  localparam logic [3:0] A_HEALTH = 4'h1;
  localparam logic [3:0] A_ACTION = 4'h2;
  localparam logic [3:0] A_GMAP = 4'h3;
  localparam logic [3:0] A_PMAP = 4'h4;
  localparam logic [3:0] A_ADMIN = 4'h5;
  localparam logic [3:0] A_CAP = 4'h6;
  localparam logic [3:0] A_NOTE = 4'h7;
  // action register bit positions
  localparam int B_RESET = 0;
  localparam int B_SELFTEST = 1;
  typedef enum logic [2:0] {
    HC_OTHER, HC_OK, HC_REP_FAIL, HC_GRP_FAIL, HC_PORT_FAIL, HC_GEN_FAIL
  } rmu_health_t;
  typedef enum logic [1:0] {ST_RUN, ST_RESET_TEST, ST_ONLINE_TEST} rmu_state_t;
  typedef struct packed {
    logic health;
    logic reset;
    logic group_map;
    logic port_map;
  } rmu_notice_t;
endpackage

/* src/rmu_top.sv */
// repeater management unit: counter, actions, notices, maps, port gates
//
// The placing of the registers and strobed register access were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// - collision count never cleared by management
// - variant 9 counts collision entry except one-port-left
// - variant 27 counts jam entry from activity above one
// - variant 41 counts every jam entry
// - reset action forces start state, runs test
// - reset test keeps counters, settings, access
// - reset notice after power-on and reset action
// - online self-test changes nothing, then health notice
// - health notice on condition change and at end of online self-test
// - notices carry current health condition
// - group map notice only on group change
// - group index unique, within group capacity
// - port capacity 1 to 1024
// - port map bit per port, 1 present
// - port map notice only on port change
// - port index unique, within port capacity
// - disabled port neither sends nor receives
// - admin setting survives reset action; power-on reset enables every port
// - admin gate overrides auto-partition
// - enabling reinitialises partition, jabber, carrier integrity
// - health encodes highest priority failure
// - group map bit per group, 1 present
module rmu_top #(
  parameter int VARIANT = rmu_pkg::VAR_9,
  parameter int NPORT = rmu_pkg::NPORT,
  parameter int NGRP = rmu_pkg::NGRP
) (
  input wire logic i_mclk,
  input wire logic i_reset_n,
  input wire logic [3:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_tx_coll_entry,
  input wire logic i_entry_from_one_left,
  input wire logic i_jam_entry,
  input wire logic i_jam_by_activity,
  input wire logic [NGRP-1:0] i_group_present,
  input wire logic [NPORT-1:0] i_port_present,
  input wire logic i_fail_rep,
  input wire logic i_fail_grp,
  input wire logic i_fail_port,
  input wire logic i_fail_gen,
  input wire logic i_health_known,
  input wire logic [NPORT-1:0] i_part_tx_en,
  input wire logic [NPORT-1:0] i_part_rx_en,
  output logic [31:0] o_rdata,
  output logic [NPORT-1:0] o_port_tx_en,
  output logic [NPORT-1:0] o_port_rx_en,
  output logic [NPORT-1:0] o_port_reinit,
  output logic o_core_restart,
  output logic o_test_busy,
  output logic [2:0] o_health_condition,
  output logic [3:0] o_notice,
  output logic [NGRP-1:0] o_group_presence_map,
  output logic [NPORT-1:0] o_port_presence_map
);
  typedef struct packed {
    logic [rmu_pkg::CNT_W-1:0] coll;
    rmu_pkg::rmu_state_t st;
    logic [4:0] tcnt;
    logic [2:0] health;
    logic [NGRP-1:0] gmap;
    logic [NPORT-1:0] pmap;
    logic [NPORT-1:0] admin;
    logic [NPORT-1:0] reinit;
    logic [NPORT-1:0] tx_en;
    logic [NPORT-1:0] rx_en;
    logic restart;
    logic busy;
    logic [3:0] notice;
    logic [3:0] sticky;
    logic pwr_pend;
    logic [31:0] rdata;
  } rmu_s_t;

  rmu_s_t s_r;
  rmu_s_t s_nxt;
  logic coll_inc;
  logic [2:0] health_now;
  logic wr_admin;

  // counting event per variant
  always_comb begin
    case (VARIANT)
      rmu_pkg::VAR_9: coll_inc = i_tx_coll_entry && !i_entry_from_one_left;
      rmu_pkg::VAR_41: coll_inc = i_jam_entry;
      default: coll_inc = i_jam_entry && i_jam_by_activity;
    endcase
  end

  // priority encode of health
  always_comb begin
    if (i_fail_rep) begin
      health_now = 3'(rmu_pkg::HC_REP_FAIL);
    end else if (i_fail_grp) begin
      health_now = 3'(rmu_pkg::HC_GRP_FAIL);
    end else if (i_fail_port) begin
      health_now = 3'(rmu_pkg::HC_PORT_FAIL);
    end else if (i_fail_gen) begin
      health_now = 3'(rmu_pkg::HC_GEN_FAIL);
    end else if (i_health_known) begin
      health_now = 3'(rmu_pkg::HC_OK);
    end else begin
      health_now = 3'(rmu_pkg::HC_OTHER);
    end
  end

  assign wr_admin = i_wr && (i_addr == rmu_pkg::A_ADMIN);

  always_comb begin
    s_nxt = s_r;
    s_nxt.notice = 4'h0;
    s_nxt.restart = 1'b0;
    s_nxt.reinit = '0;
    s_nxt.pwr_pend = 1'b0;
    // wraps, no clear path from the bus
    s_nxt.coll = s_r.coll + rmu_pkg::CNT_W'(coll_inc);
    s_nxt.health = health_now;
    s_nxt.gmap = i_group_present;
    s_nxt.pmap = i_port_present;
    if (s_r.pwr_pend) begin
      s_nxt.notice[2] = 1'b1;
    end
    if (s_r.health != health_now && !s_r.pwr_pend) begin
      s_nxt.notice[3] = 1'b1;
    end
    if (s_r.gmap != i_group_present && !s_r.pwr_pend) begin
      s_nxt.notice[1] = 1'b1;
    end
    if (s_r.pmap != i_port_present && !s_r.pwr_pend) begin
      s_nxt.notice[0] = 1'b1;
    end
    case (s_r.st)
      rmu_pkg::ST_RUN: begin
        if (i_wr && i_addr == rmu_pkg::A_ACTION && i_wdata[rmu_pkg::B_RESET]) begin
          s_nxt.st = rmu_pkg::ST_RESET_TEST;
          s_nxt.restart = 1'b1;
          s_nxt.tcnt = 5'(rmu_pkg::TEST_CYC);
        end else if (i_wr && i_addr == rmu_pkg::A_ACTION &&
                     i_wdata[rmu_pkg::B_SELFTEST]) begin
          s_nxt.st = rmu_pkg::ST_ONLINE_TEST;
          s_nxt.tcnt = 5'(rmu_pkg::TEST_CYC);
        end
      end
      rmu_pkg::ST_RESET_TEST: begin
        // core held at start; counters and admin untouched
        s_nxt.restart = 1'b1;
        s_nxt.tcnt = s_r.tcnt - 5'h01;
        if (s_r.tcnt == 5'h01) begin
          s_nxt.st = rmu_pkg::ST_RUN;
          s_nxt.restart = 1'b0;
          s_nxt.notice[2] = 1'b1;
        end
      end
      rmu_pkg::ST_ONLINE_TEST: begin
        s_nxt.tcnt = s_r.tcnt - 5'h01;
        if (s_r.tcnt == 5'h01) begin
          s_nxt.st = rmu_pkg::ST_RUN;
          s_nxt.notice[3] = 1'b1;
        end
      end
      default: s_nxt.st = rmu_pkg::ST_RUN;
    endcase
    // busy flag registered beside the state
    s_nxt.busy = (s_nxt.st != rmu_pkg::ST_RUN);
    if (wr_admin) begin
      s_nxt.admin = i_wdata[NPORT-1:0];
      s_nxt.reinit = i_wdata[NPORT-1:0] & ~s_r.admin;
    end
    // gate after auto-partition, admin wins
    s_nxt.tx_en = s_r.admin & i_part_tx_en & s_r.pmap;
    s_nxt.rx_en = s_r.admin & i_part_rx_en & s_r.pmap;
    s_nxt.sticky = s_r.sticky | s_nxt.notice;
    s_nxt.rdata = 32'h0;
    if (i_rd) begin
      case (i_addr)
        rmu_pkg::A_COLL: s_nxt.rdata = s_r.coll;
        rmu_pkg::A_HEALTH: s_nxt.rdata = {29'h0, s_r.health};
        rmu_pkg::A_ACTION: s_nxt.rdata = {31'h0, s_r.st != rmu_pkg::ST_RUN};
        rmu_pkg::A_GMAP: s_nxt.rdata = 32'(s_r.gmap);
        rmu_pkg::A_PMAP: s_nxt.rdata = 32'(s_r.pmap);
        rmu_pkg::A_ADMIN: s_nxt.rdata = 32'(s_r.admin);
        rmu_pkg::A_CAP: s_nxt.rdata = {16'(NPORT), 16'(NGRP)};
        rmu_pkg::A_NOTE: begin
          s_nxt.rdata = {28'h0, s_r.sticky};
          s_nxt.sticky = s_nxt.notice;
        end
        default: s_nxt.rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      s_r <= '0;
      s_r.pwr_pend <= 1'b1;
      s_r.admin <= '1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_rdata = s_r.rdata;
  assign o_port_tx_en = s_r.tx_en;
  assign o_port_rx_en = s_r.rx_en;
  assign o_port_reinit = s_r.reinit;
  assign o_core_restart = s_r.restart;
  assign o_test_busy = s_r.busy;
  assign o_health_condition = s_r.health;
  assign o_notice = s_r.notice;
  assign o_group_presence_map = s_r.gmap;
  assign o_port_presence_map = s_r.pmap;

  chk_coll_counts: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    coll_inc |=> s_r.coll == $past(s_r.coll) + 32'h1)
    else $error("collision count missed");
  chk_coll_hold: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    !coll_inc |=> $stable(s_r.coll)) else $error("collision count moved");
  chk_reset_done: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    (s_r.st == rmu_pkg::ST_RESET_TEST && s_r.tcnt == 5'h01) |=> o_notice[2])
    else $error("no reset notice");
  chk_test_health: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    (s_r.st == rmu_pkg::ST_ONLINE_TEST && s_r.tcnt == 5'h01) |=> o_notice[3])
    else $error("no health notice");
  chk_health_cause: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    o_notice[3] |-> ($past(s_r.st) == rmu_pkg::ST_ONLINE_TEST ||
                     $past(s_r.health) != $past(health_now)))
    else $error("spurious health notice");
  chk_gmap_cause: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    o_notice[1] |-> $past(s_r.gmap) != $past(i_group_present))
    else $error("spurious group notice");
  chk_pmap_cause: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    o_notice[0] |-> $past(s_r.pmap) != $past(i_port_present))
    else $error("spurious port notice");
  chk_admin_gate: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    (o_port_tx_en & ~$past(s_r.admin)) == '0) else $error("disabled port sends");
  chk_restart_len: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    $rose(o_core_restart) |-> o_core_restart [*8]) else $error("restart too short");
  cov_reset: cover property (@(posedge i_mclk) disable iff (!i_reset_n) o_notice[2]);
  cov_test: cover property (@(posedge i_mclk) disable iff (!i_reset_n) o_notice[3]);
  cov_coll: cover property (@(posedge i_mclk) disable iff (!i_reset_n) coll_inc);
  cov_reinit: cover property (@(posedge i_mclk) disable iff (!i_reset_n) |o_port_reinit);
  cov_gmap: cover property (@(posedge i_mclk) disable iff (!i_reset_n) o_notice[1]);

  // collision counting per variant
  chk_coll_no_clear: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    (i_wr && i_addr == rmu_pkg::A_COLL && !coll_inc) |=> s_r.coll == $past(s_r.coll))
    else $error("collision count cleared by write");
  chk_coll_wrap: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    (s_r.coll == '1 && coll_inc) |=> s_r.coll == '0)
    else $error("collision count did not wrap");
  chk_var9_filter: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    (VARIANT == rmu_pkg::VAR_9 && i_entry_from_one_left) |-> !coll_inc)
    else $error("one-port-left entry counted");
  chk_var27_cause: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    (VARIANT == rmu_pkg::VAR_27 && !i_jam_by_activity) |-> !coll_inc)
    else $error("jam without activity counted");
  chk_var41_all: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    (VARIANT == rmu_pkg::VAR_41 && i_jam_entry) |-> coll_inc)
    else $error("jam entry not counted");

  // actions and tests
  chk_reset_starts: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    (s_r.st == rmu_pkg::ST_RUN && i_wr && i_addr == rmu_pkg::A_ACTION &&
     i_wdata[rmu_pkg::B_RESET]) |=> (o_core_restart && o_test_busy))
    else $error("reset action did not start");
  chk_refuse_action: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    (s_r.st != rmu_pkg::ST_RUN) |=> s_r.tcnt == $past(s_r.tcnt) - 5'h01)
    else $error("test length disturbed");
  chk_restart_end: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    $fell(o_core_restart) |-> o_notice[2])
    else $error("restart ended without notice");
  chk_test_keeps_admin: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    (o_test_busy && !wr_admin) |=> $stable(s_r.admin))
    else $error("test touched admin settings");
  chk_online_no_restart: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    (s_r.st == rmu_pkg::ST_ONLINE_TEST) |-> !o_core_restart)
    else $error("online test restarted core");
  chk_busy_flag: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    o_test_busy == (s_r.st != rmu_pkg::ST_RUN))
    else $error("busy flag wrong");

  // notices and health
  chk_pwr_notice: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    s_r.pwr_pend |=> o_notice[2])
    else $error("no power-on reset notice");
  chk_pwr_quiet: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    s_r.pwr_pend |=> (o_notice[3] || o_notice[1] || o_notice[0]) == 1'b0)
    else $error("notice raised at power-up");
  chk_notice_kept: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    (o_notice != 4'h0) |-> ((s_r.sticky & o_notice) == o_notice))
    else $error("notice lost");
  chk_health_carried: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    (o_notice[3] || o_notice[2]) |-> o_health_condition == $past(health_now))
    else $error("notice carries stale health");
  chk_health_prio: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    (!s_r.pwr_pend && $past(i_fail_rep)) |-> o_health_condition == 3'(rmu_pkg::HC_REP_FAIL))
    else $error("health priority wrong");

  // presence maps and bus
  chk_gmap_follows: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    !s_r.pwr_pend |-> o_group_presence_map == $past(i_group_present))
    else $error("group map stale");
  chk_pmap_follows: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    !s_r.pwr_pend |-> o_port_presence_map == $past(i_port_present))
    else $error("port map stale");
  chk_gmap_moved: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    o_notice[1] |-> o_group_presence_map != $past(o_group_presence_map))
    else $error("group notice without change");
  chk_pmap_moved: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    o_notice[0] |-> o_port_presence_map != $past(o_port_presence_map))
    else $error("port notice without change");
  chk_read_idle: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    (!s_r.pwr_pend && !$past(i_rd)) |-> o_rdata == 32'h0)
    else $error("read data outside read");
  chk_caps_read: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    (!s_r.pwr_pend && $past(i_rd) && $past(i_addr) == rmu_pkg::A_CAP) |->
    o_rdata == {16'(NPORT), 16'(NGRP)})
    else $error("capacity read wrong");

  // per-port gate and re-enable checks
  for (genvar g = 0; g < NPORT; g++) begin : g_port
    chk_rx_gate: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
      o_port_rx_en[g] |-> $past(s_r.admin[g]))
      else $error("disabled port receives");
    chk_part_wins: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
      o_port_tx_en[g] |-> $past(i_part_tx_en[g]))
      else $error("partitioned port sends");
    chk_reinit_edge: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
      o_port_reinit[g] |-> (s_r.admin[g] && !$past(s_r.admin[g])))
      else $error("reinit without enable");
  end
endmodule
`default_nettype wire

/* test/rmu_top_bench.sv */
// self-checking bench for the repeater management unit
`timescale 1ns/100ps
`default_nettype none
module rmu_top_bench;
  logic i_mclk = 1'b0;
  logic i_reset_n = 1'b0;
  logic [3:0] i_addr = 4'h0;
  logic [31:0] i_wdata = 32'h0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic coll = 1'b0;
  logic one_left = 1'b0;
  logic jam = 1'b0;
  logic jam_act = 1'b0;
  logic [3:0] grp = 4'hF;
  logic [7:0] prt = 8'hFF;
  logic f_rep = 1'b0;
  logic f_port = 1'b0;
  logic [7:0] ptx = 8'hFF;
  logic [7:0] prx = 8'hFF;
  logic [31:0] o_rdata;
  logic [7:0] o_port_tx_en, o_port_rx_en, o_port_reinit, o_port_presence_map;
  logic o_core_restart, o_test_busy;
  logic [2:0] o_health_condition;
  logic [3:0] o_notice, o_group_presence_map;
  logic [31:0] exp_q[$];
  logic [31:0] exp_r;
  logic [31:0] seed = 32'h0A9A;
  logic rd_d = 1'b0;
  int n_fail = 0;
  int n_compared = 0;
  logic [31:0] rdata_v27;
  logic [31:0] rdata_v41;
  rmu_top #(.VARIANT(rmu_pkg::VAR_9), .NPORT(8), .NGRP(4)) dut (
    .i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .i_tx_coll_entry(coll), .i_entry_from_one_left(one_left),
    .i_jam_entry(jam), .i_jam_by_activity(jam_act), .i_group_present(grp),
    .i_port_present(prt), .i_fail_rep(f_rep), .i_fail_grp(1'b0), .i_fail_port(f_port),
    .i_fail_gen(1'b0), .i_health_known(1'b1), .i_part_tx_en(ptx), .i_part_rx_en(prx),
    .o_rdata(o_rdata), .o_port_tx_en(o_port_tx_en), .o_port_rx_en(o_port_rx_en),
    .o_port_reinit(o_port_reinit), .o_core_restart(o_core_restart),
    .o_test_busy(o_test_busy), .o_health_condition(o_health_condition),
    .o_notice(o_notice), .o_group_presence_map(o_group_presence_map),
    .o_port_presence_map(o_port_presence_map));
  rmu_top #(.VARIANT(rmu_pkg::VAR_27), .NPORT(8), .NGRP(4)) dut_v27 (
    .i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .i_tx_coll_entry(coll), .i_entry_from_one_left(one_left),
    .i_jam_entry(jam), .i_jam_by_activity(jam_act), .i_group_present(grp),
    .i_port_present(prt), .i_fail_rep(f_rep), .i_fail_grp(1'b0), .i_fail_port(f_port),
    .i_fail_gen(1'b0), .i_health_known(1'b1), .i_part_tx_en(ptx), .i_part_rx_en(prx),
    .o_rdata(rdata_v27), .o_port_tx_en(), .o_port_rx_en(), .o_port_reinit(),
    .o_core_restart(), .o_test_busy(), .o_health_condition(), .o_notice(),
    .o_group_presence_map(), .o_port_presence_map());
  rmu_top #(.VARIANT(rmu_pkg::VAR_41), .NPORT(8), .NGRP(4)) dut_v41 (
    .i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .i_tx_coll_entry(coll), .i_entry_from_one_left(one_left),
    .i_jam_entry(jam), .i_jam_by_activity(jam_act), .i_group_present(grp),
    .i_port_present(prt), .i_fail_rep(f_rep), .i_fail_grp(1'b0), .i_fail_port(f_port),
    .i_fail_gen(1'b0), .i_health_known(1'b1), .i_part_tx_en(ptx), .i_part_rx_en(prx),
    .o_rdata(rdata_v41), .o_port_tx_en(), .o_port_rx_en(), .o_port_reinit(),
    .o_core_restart(), .o_test_busy(), .o_health_condition(), .o_notice(),
    .o_group_presence_map(), .o_port_presence_map());
  always #12.5 i_mclk = ~i_mclk;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_mclk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge i_mclk);
    i_addr <= a;
    i_rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge i_mclk);
    i_rd <= 1'b0;
  endtask
  task automatic wait_idle;
    int n;
    n = 0;
    while (o_test_busy !== 1'b0 && n < 100) begin
      @(negedge i_mclk);
      n++;
    end
    if (n >= 100) begin
      n_fail++;
      $display("MISMATCH %0t test never finished", $time);
    end
  endtask
  task automatic report_and_stop;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // read data checker, oldest note first
  always @(posedge i_mclk) rd_d <= i_rd;
  always @(negedge i_mclk) begin
    if (rd_d) begin
      exp_r = exp_q.pop_front();
      chk(o_rdata, exp_r);
    end
  end
  initial begin
    repeat (20000) @(posedge i_mclk);
    n_fail++;
    report_and_stop();
  end
  initial begin
    repeat (12) @(posedge i_mclk);
    i_reset_n <= 1'b1;
    rd(rmu_pkg::A_NOTE, 32'h4);
    rd(rmu_pkg::A_NOTE, 32'h0);
    $display("test power-on done");
    for (int k = 0; k < 5; k++) begin
      @(posedge i_mclk);
      coll <= (k < 3);
      one_left <= (k == 1);
      jam <= (k >= 3);
      jam_act <= (k == 3);
    end
    @(posedge i_mclk);
    coll <= 1'b0;
    jam <= 1'b0;
    wr(rmu_pkg::A_COLL, 32'hFFFF_FFFF);
    rd(rmu_pkg::A_COLL, 32'h2);
    @(negedge i_mclk);
    chk(rdata_v27, 32'h1);
    chk(rdata_v41, 32'h2);
    $display("test collision count done");
    @(posedge i_mclk);
    f_port <= 1'b1;
    f_rep <= 1'b1;
    repeat (3) @(posedge i_mclk);
    rd(rmu_pkg::A_HEALTH, 32'h2);
    rd(rmu_pkg::A_NOTE, 32'h8);
    grp <= 4'h7;
    prt <= 8'h7F;
    repeat (3) @(posedge i_mclk);
    rd(rmu_pkg::A_GMAP, 32'h7);
    rd(rmu_pkg::A_PMAP, 32'h7F);
    rd(rmu_pkg::A_NOTE, 32'h3);
    rd(rmu_pkg::A_CAP, 32'h0008_0004);
    @(negedge i_mclk);
    chk({29'h0, o_health_condition}, 32'h2);
    chk({28'h0, o_group_presence_map}, 32'h7);
    chk({24'h0, o_port_presence_map}, 32'h7F);
    $display("test health and maps done");
    wr(rmu_pkg::A_ADMIN, 32'hFE);
    for (int k = 0; k < 8; k++) begin
      @(posedge i_mclk);
      seed = xs(seed);
      ptx <= seed[7:0];
      prx <= seed[15:8];
      repeat (2) @(posedge i_mclk);
      @(negedge i_mclk);
      chk({24'h0, o_port_tx_en}, {24'h0, ptx & 8'h7E});
      chk({24'h0, o_port_rx_en}, {24'h0, prx & 8'h7E});
    end
    $display("test port gates done");
    wr(rmu_pkg::A_ACTION, 32'h1);
    @(negedge i_mclk);
    chk({31'h0, o_core_restart}, 32'h1);
    wait_idle();
    rd(rmu_pkg::A_NOTE, 32'h4);
    rd(rmu_pkg::A_COLL, 32'h2);
    rd(rmu_pkg::A_ADMIN, 32'hFE);
    $display("test reset action done");
    wr(rmu_pkg::A_ACTION, 32'h2);
    @(negedge i_mclk);
    chk({31'h0, o_test_busy}, 32'h1);
    wait_idle();
    rd(rmu_pkg::A_NOTE, 32'h8);
    rd(rmu_pkg::A_HEALTH, 32'h2);
    wr(rmu_pkg::A_ADMIN, 32'hFF);
    @(negedge i_mclk);
    chk({24'h0, o_port_reinit}, 32'h1);
    $display("test self-test and enable done");
    repeat (4) @(posedge i_mclk);
    report_and_stop();
  end
endmodule
`default_nettype wire
